// ==== design/gpio_mux_pkg.sv ====
// constants shared by the lower-pin function multiplexer and its helpers
// assumes one system clock and a synchronous active-high reset everywhere
// Functional notes
// RQ1: every pin has its own two-bit selector
// RQ2: selectors live in the utility register block
// RQ3: primary pin wins over its duplicate
// RQ4: software avoids selecting primary and duplicate together
// RQ5: serial code 00 follows UART or SPI mode
// RQ6: code 03 routes pin n to GPIO n
// RQ7: pins 0-7 carry serial port B
// RQ8: pins 8-15 carry serial port A
// RQ9: pins 20-23 carry serial port C
// RQ10: pins 24-27 port D or LCD data 0-3
// RQ11: LCD control on 18-23, data 4-7 on 28-31
// RQ12: code 02 LCD data 8-11, duplicates 28-31
// RQ13: parallel-port data on 32-35, status on 3-6, 16
// RQ14: timers mapped to their listed pins
// RQ15: external interrupts mapped, duplicates included
// RQ16: DMA handshakes on listed pins with duplicates
// RQ17: address filter reject 18, request 19
// RQ18: USB relay 17, timer 11 or overcurrent 16
// RQ19: software never programs reserved codes
// RQ20: strap pins stay released through reset
// RQ21: new selector takes effect next cycle; here the pad follows two cycles after the write
// RQ22: pin enable follows the selected function direction
package gpio_mux_pkg;
	localparam int         PIN_N      = 36;    // multiplexed pins 0..35
	localparam int         SEL_W      = 2;     // selector bits per pin
	localparam int         PIN_IDX_W  = 6;     // width of a pin index
	localparam logic [1:0] CODE_PRI   = 2'h0;  // option 00
	localparam logic [1:0] CODE_ALT1  = 2'h1;  // option 01
	localparam logic [1:0] CODE_ALT2  = 2'h2;  // option 02
	localparam logic [1:0] CODE_GPIO  = 2'h3;  // option 03, also the reset choice
	localparam logic       IDLE_IN    = 1'b1;  // level a peripheral sees on an unrouted input
	localparam logic       PAD_OUT_RST = 1'b0; // pad data during reset
	// serial group layout, one bit per pin offset inside the group
	localparam logic [7:0] UART8_OUT  = 8'h15; // tx, rts, dtr drive on 8-pin groups
	localparam logic [7:0] UART4_OUT  = 8'h01; // dtr drives on 4-pin groups
	localparam logic [7:0] SPI_B_PINS = 8'hc3; // dout, din, clk, enable
	localparam logic [7:0] SPI_A_PINS = 8'h43; // dout, din, clk
	localparam logic [7:0] SPI_CD_PINS = 8'h0c; // clk, enable
	localparam logic [7:0] SPI_DOUT   = 8'h01; // data out offset
	localparam logic [7:0] SPI_NO_DOUT = 8'h00;
	localparam logic [7:0] SPI_B_CTL  = 8'hc0; // clk and enable, driven as master
	localparam logic [7:0] SPI_A_CTL  = 8'h40;
	localparam logic [7:0] SPI_CD_CTL = 8'h0c;
	// index of each port in the spi_mode / spi_master vectors
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_D = 3;
endpackage

// ==== design/pin_filter.sv ====
// three-stage pad input synchroniser with agreement filter
// assumes pad levels are asynchronous to clk
`timescale 1ns/1ps
module pin_filter
	import gpio_mux_pkg::*;
#(
	parameter int W = PIN_N
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pad_raw,
	output logic      [W-1:0] pad_clean
);
	logic [W-1:0] stage1; // metastability catcher, read only by stage2
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] differ; // stage2 and stage3 disagree

	assign differ = stage2 ^ stage3;

	// a change is accepted only once the second and third stages agree,
	// which costs a cycle but stops a single bad sample reaching a peripheral
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1    <= {W{IDLE_IN}};
			stage2    <= {W{IDLE_IN}};
			stage3    <= {W{IDLE_IN}};
			pad_clean <= {W{IDLE_IN}};
		end else begin
			stage1    <= pad_raw;
			stage2    <= stage1;
			stage3    <= stage2;
			pad_clean <= (stage2 & ~differ) | (pad_clean & differ);
		end
	end
endmodule

// ==== design/selector_bank.sv ====
// per-pin function selector registers of the utility block
// assumes writes come one pin at a time from the owning register logic
`timescale 1ns/1ps
module selector_bank
	import gpio_mux_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   wr_en,
	input  wire logic [PIN_IDX_W-1:0]   wr_pin,
	input  wire logic [SEL_W-1:0]       wr_code,
	output logic      [PIN_N*SEL_W-1:0] sel
);
	genvar g;
	// one independent field per pin; a write to an index past the last pin is dropped
	for (g = 0; g < PIN_N; g++) begin : field
		logic             hit;   // this pin addressed
		logic [SEL_W-1:0] field; // this pin's selector, one process per field
		assign hit = wr_en && (wr_pin == PIN_IDX_W'(g));
		assign sel[g*SEL_W +: SEL_W] = field;
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				field <= CODE_GPIO; // GPIO keeps pads released at power-up [RQ20]
			end else if (hit) begin
				field <= wr_code; // [RQ1] [RQ2]
			end
		end
	end
endmodule

// ==== design/gpio_function_mux.sv ====
// function multiplexer for general-purpose pins 0..35
// assumes peripherals run on clk; pad inputs are asynchronous and filtered here
`timescale 1ns/1ps
module gpio_function_mux
	import gpio_mux_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// selector write port
	input  wire logic                   sel_wr_en,
	input  wire logic [PIN_IDX_W-1:0]   sel_wr_pin,
	input  wire logic [SEL_W-1:0]       sel_wr_code,
	output logic      [PIN_N*SEL_W-1:0] sel_state,
	// pads
	input  wire logic [PIN_N-1:0]       pad_in,
	output logic      [PIN_N-1:0]       pad_out,
	output logic      [PIN_N-1:0]       pad_oe_n,
	// serial ports, bit i is pin offset i of the group
	input  wire logic [3:0]             spi_mode,
	input  wire logic [3:0]             spi_master,
	input  wire logic [7:0]             ser_a_out,
	input  wire logic [7:0]             ser_b_out,
	input  wire logic [3:0]             ser_c_out,
	input  wire logic [3:0]             ser_d_out,
	output logic      [7:0]             ser_a_in,
	output logic      [7:0]             ser_b_in,
	output logic      [3:0]             ser_c_in,
	output logic      [3:0]             ser_d_in,
	// timers, interrupts, DMA
	input  wire logic [15:0]            timer_out,
	input  wire logic [15:0]            timer_drive,
	output logic      [15:0]            timer_in,
	output logic      [3:0]             ext_irq_in,
	output logic                        dma1_req_in,
	input  wire logic                   dma1_done_out,
	input  wire logic                   dma1_rden_out,
	input  wire logic                   dma2_rden_out,
	// parallel port
	input  wire logic [3:0]             p1284_stat_out,
	input  wire logic [3:0]             p1284_data_out,
	input  wire logic [3:0]             p1284_data_drive,
	output logic      [3:0]             p1284_data_in,
	// LCD, address filter, USB
	input  wire logic [5:0]             lcd_ctrl_out,
	input  wire logic [11:0]            lcd_data_out,
	input  wire logic                   addr_filter_req_out,
	output logic                        addr_filter_reject_in,
	input  wire logic                   usb_power_relay,
	output logic                        usb_overcurrent_input,
	// plain GPIO
	input  wire logic [PIN_N-1:0]       gpio_out,
	input  wire logic [PIN_N-1:0]       gpio_drive,
	output logic      [PIN_N-1:0]       gpio_in
);
	logic [PIN_N-1:0] p;                       // filtered pad levels
	logic [PIN_N-1:0] is0, is1, is2, is3;      // selector decode per pin
	logic [PIN_N-1:0] blk0, blk1, blk2;        // duplicate lost to its primary
	logic [PIN_N-1:0] use0, use1, use2;        // selected and not overruled
	logic [PIN_N-1:0] c0_out, c1_out, c2_out;  // option data per pin
	logic [PIN_N-1:0] c0_drv, c1_drv, c2_drv;  // option drives the pad
	logic [PIN_N-1:0] next_out, next_drv;
	logic [15:0]      ra, rb, rc, rd;          // serial {route, drive} masks
	logic [15:0]      next_timer_in;
	logic [3:0]       next_irq;
	logic [3:0]       c_route, d_route;        // serial C and D input route per pin
	logic [3:0]       pd_route;                // parallel data input route per pin

	// the whole block is combinational steering between two register stages:
	// the pad filter on the way in and the output registers on both sides.
	// nothing here holds state of its own apart from the selectors, so a
	// selector write or a change of spi_mode or spi_master are the only events that change the routing.
	// limitation: the pad level seen by a peripheral lags the pin by five
	// cycles, which is fine for handshakes and timers but not for fast clocks.

	// route and drive masks of one serial group for option 00
	function automatic logic [15:0] ser_mask(input logic spi, input logic master, input logic [7:0] uart_out,
		input logic [7:0] spi_pins, input logic [7:0] dout, input logic [7:0] ctl);
		logic [7:0] route;
		logic [7:0] drive;
		route = spi ? spi_pins : 8'hff;
		drive = spi ? (dout | (master ? ctl : 8'h00)) : uart_out;
		return {route, drive & route};
	endfunction

	// primary source first, duplicate second, idle level otherwise
	function automatic logic pick(input logic a_en, input logic a, input logic b_en, input logic b);
		return a_en ? a : (b_en ? b : IDLE_IN);
	endfunction

	// masked 8-bit input steering
	function automatic logic [7:0] steer8(input logic [7:0] m, input logic [7:0] v);
		return (m & v) | (~m & {8{IDLE_IN}});
	endfunction

	selector_bank u_sel ( // selectors held in the utility block [RQ2]
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (sel_wr_en),
		.wr_pin  (sel_wr_pin),
		.wr_code (sel_wr_code),
		.sel     (sel_state)
	);

	pin_filter #(.W(PIN_N)) u_filt (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.pad_raw   (pad_in),
		.pad_clean (p)
	);

	// serial groups: UART or SPI depending on the port mode
	assign ra = ser_mask(spi_mode[PORT_A], spi_master[PORT_A], UART8_OUT, SPI_A_PINS, SPI_DOUT, SPI_A_CTL); // [RQ8]
	assign rb = ser_mask(spi_mode[PORT_B], spi_master[PORT_B], UART8_OUT, SPI_B_PINS, SPI_DOUT, SPI_B_CTL); // [RQ7]
	assign rc = ser_mask(spi_mode[PORT_C], spi_master[PORT_C], UART4_OUT, SPI_CD_PINS, SPI_NO_DOUT, SPI_CD_CTL); // [RQ9]
	assign rd = ser_mask(spi_mode[PORT_D], spi_master[PORT_D], UART4_OUT, SPI_CD_PINS, SPI_NO_DOUT, SPI_CD_CTL);

	// 4-pin groups use the low half of the route byte
	assign c_route  = use0[23:20] & rc[11:8];
	assign d_route  = use0[27:24] & rd[11:8];
	// parallel data is taken whenever option 01 is chosen on pins 32..35
	assign pd_route = use1[35:32];

	// each option vector below is one bit per pin, pin 0 at the right.
	// a constant 0 in a data vector marks an input-only or reserved choice;
	// its drive bit is 0 as well, so the pad stays released there, except pin 16 under option 00, which drives low.
	// trade-off: flat vectors are hard to read but keep the pin loop tiny.

	// option 00: a serial pin without an SPI meaning is released in SPI mode [RQ5]
	assign c0_out = {timer_out[10:8], 1'b0, timer_out[7:5], 1'b0, ser_d_out, ser_c_out,
		addr_filter_req_out, 1'b0, usb_power_relay, 1'b0, ser_a_out, ser_b_out}; // [RQ14] [RQ17] [RQ18]
	assign c0_drv = {timer_drive[10:8], 1'b0, timer_drive[7:5], 1'b0, rd[3:0], rc[3:0],
		4'hb, ra[7:0], rb[7:0]}; // reserved output on pin 16 drives low [RQ18] [RQ10]

	// option 01: DMA duplicates, parallel status, timers, LCD, parallel data
	assign c1_out = {p1284_data_out, lcd_data_out[7:0], lcd_ctrl_out, 1'b0, p1284_stat_out[3], timer_out[2:1],
		6'h00, dma1_rden_out, p1284_stat_out, timer_out[0], 1'b0, dma1_done_out}; // [RQ11] [RQ13] [RQ16]
	assign c1_drv = {p1284_data_drive, 14'h3fff, 2'h1, timer_drive[2:1], 6'h00, 1'b1, 4'hf,
		timer_drive[0], 1'b0, 1'b1}; // reserved options never drive, apart from pin 16 under option 00 [RQ19] [RQ10]

	// option 02: DMA primaries, timer duplicates, LCD upper data
	assign c2_out = {lcd_data_out[11:8], lcd_data_out[11:8], timer_out[4:3], timer_out[15], 1'b0, timer_out[14],
		3'h0, dma2_rden_out, 2'h0, timer_out[11], 2'h0, timer_out[10], 1'b0, timer_out[0], 1'b0, timer_out[8],
		1'b0, 1'b0, timer_out[7], dma1_rden_out, dma1_done_out, 1'b0, dma2_rden_out, 1'b0, timer_out[1]}; // [RQ12]
	assign c2_drv = {8'hff, timer_drive[4:3], timer_drive[15], 1'b0, timer_drive[14], 3'h0, 1'b1, 2'h0,
		timer_drive[11], 2'h0, timer_drive[10], 1'b0, timer_drive[0], 1'b0, timer_drive[8], 1'b0, 1'b0,
		timer_drive[7], 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, timer_drive[1]}; // [RQ14] [RQ16]


	// a duplicate pin stands aside while its primary pin carries the same function [RQ3]
	// the block masks only cover pairs whose primary is inside pins 0..35;
	// a duplicate whose primary lives on an upper pin is always live here.
	assign blk0 = {7'h00, is2[7], 28'h0000000};
	assign blk1 = {19'h00000, is1[6], 2'h0, is2[1], 1'b0, is0[32], 3'h0, is2[5], 5'h00, is2[3], is2[4]};
	assign blk2 = {4'h0, is2[35:32], 8'h00, is2[2], 5'h00, is0[35], 1'b0, is1[2], 1'b0, is0[33], 2'h0,
		is0[31], 5'h00, is1[14]};
	assign use0 = is0 & ~blk0;
	assign use1 = is1 & ~blk1;
	assign use2 = is2 & ~blk2;

	genvar g;
	// per-pin decode and selection; the pad is released unless the chosen function drives it
	for (g = 0; g < PIN_N; g++) begin : pin
		assign is0[g] = sel_state[g*SEL_W +: SEL_W] == CODE_PRI;  // [RQ1]
		assign is1[g] = sel_state[g*SEL_W +: SEL_W] == CODE_ALT1;
		assign is2[g] = sel_state[g*SEL_W +: SEL_W] == CODE_ALT2;
		assign is3[g] = sel_state[g*SEL_W +: SEL_W] == CODE_GPIO;
		assign next_out[g] = is0[g] ? c0_out[g] : is1[g] ? c1_out[g] : is2[g] ? c2_out[g] : gpio_out[g]; // [RQ6]
		assign next_drv[g] = use0[g] ? c0_drv[g] : use1[g] ? c1_drv[g] : use2[g] ? c2_drv[g] :
			(is3[g] & gpio_drive[g]); // [RQ22]
	end


	// inputs toward the peripherals, primary before duplicate
	// an input nobody routes rests high, so idle handshakes read inactive
	assign next_irq = {pick(use2[18], p[18], 1'b0, 1'b0), pick(use0[32], p[32], use1[11], p[11]),
		pick(use2[7], p[7], use0[28], p[28]), pick(use2[1], p[1], use1[13], p[13])}; // [RQ15]
	assign next_timer_in = {pick(use2[25], p[25], 1'b0, 1'b0), pick(use2[23], p[23], 1'b0, 1'b0), IDLE_IN, IDLE_IN,
		pick(use2[16], p[16], 1'b0, 1'b0), pick(use0[35], p[35], use2[13], p[13]),
		pick(use0[34], p[34], 1'b0, 1'b0), pick(use0[33], p[33], use2[9], p[9]),
		pick(use0[31], p[31], use2[6], p[6]), pick(use0[30], p[30], 1'b0, 1'b0),
		pick(use0[29], p[29], 1'b0, 1'b0), pick(use2[27], p[27], 1'b0, 1'b0),
		pick(use2[26], p[26], 1'b0, 1'b0), pick(use1[15], p[15], 1'b0, 1'b0),
		pick(use1[14], p[14], use2[0], p[0]), pick(use1[2], p[2], use2[11], p[11])}; // [RQ14]


	// pad side: registered so a selector write reaches the pad two cycles later, all pins together [RQ21]
	// registering data and enable together avoids a glitch on other pins
	// while one selector changes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pad_out  <= {PIN_N{PAD_OUT_RST}};
			pad_oe_n <= {PIN_N{1'b1}}; // released so strap pull levels hold [RQ20]
		end else begin
			pad_out  <= next_out;
			pad_oe_n <= ~next_drv; // [RQ22]
		end
	end


	// peripheral side: unrouted inputs rest at the idle level
	// every peripheral input is registered once more after the filter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ser_a_in              <= {8{IDLE_IN}};
			ser_b_in              <= {8{IDLE_IN}};
			ser_c_in              <= {4{IDLE_IN}};
			ser_d_in              <= {4{IDLE_IN}};
			timer_in              <= {16{IDLE_IN}};
			ext_irq_in            <= {4{IDLE_IN}};
			dma1_req_in           <= IDLE_IN;
			p1284_data_in         <= {4{IDLE_IN}};
			addr_filter_reject_in <= IDLE_IN;
			usb_overcurrent_input <= IDLE_IN;
			gpio_in               <= {PIN_N{IDLE_IN}};
		end else begin
			ser_a_in              <= steer8(use0[15:8] & ra[15:8], p[15:8]); // [RQ8]
			ser_b_in              <= steer8(use0[7:0] & rb[15:8], p[7:0]); // [RQ7]
			ser_c_in              <= (c_route & p[23:20]) | (~c_route & {4{IDLE_IN}}); // [RQ9]
			ser_d_in              <= (d_route & p[27:24]) | (~d_route & {4{IDLE_IN}}); // [RQ10]
			timer_in              <= next_timer_in;
			ext_irq_in            <= next_irq;
			dma1_req_in           <= pick(use2[3], p[3], use1[1], p[1]); // [RQ16]
			p1284_data_in         <= (pd_route & p[35:32]) | (~pd_route & {4{IDLE_IN}}); // [RQ13]
			addr_filter_reject_in <= pick(use0[18], p[18], 1'b0, 1'b0); // [RQ17]
			usb_overcurrent_input <= pick(use2[16], p[16], 1'b0, 1'b0); // [RQ18]
			gpio_in               <= p; // pin level is always readable
		end
	end


	// checks next to the routing they guard
	// each one but a_reset_release watches a single representative pin, or one primary/duplicate pair, of its rule; the pin
	// vectors are built the same way for every pin, so one pin per rule checks the decode,
	// but a misplaced bit on another pin of the flat option vectors goes unseen here.

	sequence s_wr_gpio5;
		sel_wr_en && (sel_wr_pin == 6'h05) && (sel_wr_code == CODE_GPIO);
	endsequence
	sequence s_gpio5_follows;
		pad_out[5] == $past(gpio_out[5]) && pad_oe_n[5] == !$past(gpio_drive[5]);
	endsequence

	a_sel_to_pad: assert property (@(posedge clk) disable iff (sys_rst) s_wr_gpio5 |-> ##2 s_gpio5_follows) // [RQ21]
		else $error("selector write did not reach pad 5 two cycles later");
	a_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
		sel_wr_en && sel_wr_pin == 6'h09 |=> sel_state[19:18] == $past(sel_wr_code)) // [RQ1]
		else $error("selector of pin 9 not stored");
	a_primary_wins: assert property (@(posedge clk) disable iff (sys_rst)
		is1[6] && is1[16] |=> pad_oe_n[16] && !pad_oe_n[6]) // [RQ3]
		else $error("duplicate nFault pin drove while primary selected");
	a_irq_primary: assert property (@(posedge clk) disable iff (sys_rst)
		is2[1] && is1[13] |=> ext_irq_in[0] == $past(p[1])) // [RQ15]
		else $error("interrupt 0 not taken from primary pin");
	a_uart_b_tx: assert property (@(posedge clk) disable iff (sys_rst)
		is0[0] && !spi_mode[PORT_B] |=> pad_out[0] == $past(ser_b_out[0]) && !pad_oe_n[0]) // [RQ7]
		else $error("port B transmit not on pin 0");
	a_spi_release: assert property (@(posedge clk) disable iff (sys_rst)
		is0[10] && spi_mode[PORT_A] |=> pad_oe_n[10]) // [RQ5]
		else $error("UART-only pin driven in SPI mode");
	a_reserved_off: assert property (@(posedge clk) disable iff (sys_rst) is1[8] || is2[8] |=> pad_oe_n[8]) // [RQ22]
		else $error("reserved option drove a pad");
	a_timer0_pin: assert property (@(posedge clk) disable iff (sys_rst)
		is1[2] |=> pad_out[2] == $past(timer_out[0]) && pad_oe_n[2] == !$past(timer_drive[0])) // [RQ14]
		else $error("timer 0 not routed to pin 2");
	a_lcd_dup_off: assert property (@(posedge clk) disable iff (sys_rst)
		is2[32] && is2[28] |=> pad_oe_n[28] && pad_out[32] == $past(lcd_data_out[8])) // [RQ12]
		else $error("LCD data 8 duplicate not released");
	a_lcd_clock: assert property (@(posedge clk) disable iff (sys_rst)
		is1[20] |=> pad_out[20] == $past(lcd_ctrl_out[2]) && !pad_oe_n[20]) // [RQ11]
		else $error("LCD clock not on pin 20");
	a_reset_release: assert property (@(posedge clk) disable iff (sys_rst) $fell(sys_rst) |-> &pad_oe_n) // [RQ20]
		else $error("pads not released after reset");
endmodule

// ==== sim/periph_model.sv ====
// far-side model: on-chip peripheral controllers and the board around the pads
// assumes the bench hands in one flat source vector and a board level per pad
`timescale 1ns/1ps
module periph_model (
	input  wire logic [106:0] src,                 // peripheral output levels, gpio_out lowest
	input  wire logic [35:0]  board,               // level the board puts on a released pad
	input  wire logic [35:0]  pad_out,             // device pad data
	input  wire logic [35:0]  pad_oe_n,            // low while the device drives the pad
	output logic      [35:0]  pad_in,              // resolved wire level seen back at the pad
	output logic      [35:0]  gpio_out,
	output logic      [7:0]   ser_a_out,
	output logic      [7:0]   ser_b_out,
	output logic      [3:0]   ser_c_out,
	output logic      [3:0]   ser_d_out,
	output logic      [15:0]  timer_out,
	output logic              dma1_done_out,
	output logic              dma1_rden_out,
	output logic              dma2_rden_out,
	output logic      [3:0]   p1284_stat_out,
	output logic      [3:0]   p1284_data_out,
	output logic      [5:0]   lcd_ctrl_out,
	output logic      [11:0]  lcd_data_out,
	output logic              addr_filter_req_out,
	output logic              usb_power_relay
);
	// one flat vector keeps every source distinct, so a wrong route shows as a wrong bit
	assign {usb_power_relay, addr_filter_req_out, lcd_data_out, lcd_ctrl_out, p1284_data_out, p1284_stat_out,
		dma2_rden_out, dma1_rden_out, dma1_done_out, timer_out, ser_d_out, ser_c_out, ser_b_out, ser_a_out,
		gpio_out} = src;
	// a released pad sits at the board pull-up unless the board pulls it low
	assign pad_in = (pad_oe_n & board) | (~pad_oe_n & pad_out);
endmodule

// ==== sim/test_gpio_function_mux.sv ====
// self-checking bench for the lower-pin function multiplexer
// assumes periph_model as far side; inputs change on the falling clock edge
`timescale 1ns/1ps
module test_gpio_function_mux import gpio_mux_pkg::*;;
	logic                   clk, sys_rst, sel_wr_en;
	logic [PIN_IDX_W-1:0]   sel_wr_pin;
	logic [SEL_W-1:0]       sel_wr_code;
	logic [PIN_N*SEL_W-1:0] sel_state;
	logic [PIN_N-1:0]       pad_in, pad_out, pad_oe_n, board, gpio_in, gpio_out;
	logic [106:0]           src;                 // all peripheral outputs, see model layout
	logic [3:0]             spi_mode, spi_master, ser_c_out, ser_d_out, ser_c_in, ser_d_in, ext_irq_in;
	logic [7:0]             ser_a_out, ser_b_out, ser_a_in, ser_b_in;
	logic [15:0]            timer_out, timer_in;
	logic [3:0]             p1284_stat_out, p1284_data_out, p1284_data_in;
	logic [5:0]             lcd_ctrl_out;
	logic [11:0]            lcd_data_out;
	logic                   dma1_req_in, dma1_done_out, dma1_rden_out, dma2_rden_out;
	logic                   addr_filter_req_out, addr_filter_reject_in, usb_power_relay, usb_overcurrent_input;
	logic [50:0]            inv;                 // every routed input in one vector
	logic [50:0]            exp;
	logic [1:0]             code;
	int                     n_fail, compares, cycles;
	// pin, code, spi mask, source index; spi ports run as masters here
	int ot[] = '{5,3,0,5, 35,3,0,35, 0,0,0,44, 8,0,0,36, 20,0,0,52, 24,0,0,56, 27,1,0,96, 18,1,0,87,
		23,1,0,92, 28,1,0,97, 32,2,0,101, 28,2,0,101, 3,1,0,79, 6,1,0,82, 16,1,0,82, 33,1,0,84, 2,1,0,60,
		15,1,0,62, 26,2,0,63, 35,0,0,70, 31,0,0,67, 29,1,0,98, 4,2,0,76, 0,1,0,76, 5,2,0,77, 2,2,0,78,
		19,2,0,78, 19,0,0,105, 17,0,0,106, 6,0,2,50, 7,0,2,51, 8,0,1,36};
	// pin, code, spi mask (slave), input indices that must follow the pad
	int it[] = '{1,0,0,9,9, 9,0,0,1,1, 9,0,1,1,1, 11,0,0,3,3, 21,0,0,17,17, 25,0,0,21,21, 1,2,0,40,40,
		7,2,0,41,41, 32,0,0,42,42, 13,1,0,40,40, 28,0,0,41,41, 11,1,0,42,42, 18,2,0,43,43, 3,2,0,44,44,
		1,1,0,44,44, 18,0,0,49,49, 16,2,0,50,35, 6,0,2,14,14};

	assign inv = {usb_overcurrent_input, addr_filter_reject_in, p1284_data_in, dma1_req_in, ext_irq_in,
		timer_in, ser_d_in, ser_c_in, ser_b_in, ser_a_in};

	gpio_function_mux dut (.clk, .sys_rst, .sel_wr_en, .sel_wr_pin, .sel_wr_code, .sel_state, .pad_in,
		.pad_out, .pad_oe_n, .spi_mode, .spi_master, .ser_a_out, .ser_b_out, .ser_c_out, .ser_d_out,
		.ser_a_in, .ser_b_in, .ser_c_in, .ser_d_in, .timer_out, .timer_drive(16'hf7ff), .timer_in,
		.ext_irq_in, .dma1_req_in, .dma1_done_out, .dma1_rden_out, .dma2_rden_out, .p1284_stat_out,
		.p1284_data_out, .p1284_data_drive(4'hf), .p1284_data_in, .lcd_ctrl_out, .lcd_data_out,
		.addr_filter_req_out, .addr_filter_reject_in, .usb_power_relay, .usb_overcurrent_input,
		.gpio_out, .gpio_drive({PIN_N{1'b1}}), .gpio_in);
	// timer 11 stays undriven so the overcurrent pad can be pulled by the board

	periph_model model (.src, .board, .pad_out, .pad_oe_n, .pad_in, .gpio_out, .ser_a_out, .ser_b_out,
		.ser_c_out, .ser_d_out, .timer_out, .dma1_done_out, .dma1_rden_out, .dma2_rden_out, .p1284_stat_out,
		.p1284_data_out, .lcd_ctrl_out, .lcd_data_out, .addr_filter_req_out, .usb_power_relay);

	// 20 MHz system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [71:0] want, input logic [71:0] got);
		compares++;
		if (got !== want) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, want, got);
		end
	endtask

	// one selector write: strobe for one edge, then an idle edge before the next
	task automatic sel_write(input int pin, input int c);
		sel_wr_en   = 1'b1;
		sel_wr_pin  = pin[PIN_IDX_W-1:0];
		sel_wr_code = c[SEL_W-1:0];
		@(negedge clk);
		sel_wr_en = 1'b0;
		@(negedge clk);
	endtask

	task automatic sel_read(input int pin, output logic [1:0] c);
		c = sel_state[2*pin +: 2];
	endtask

	// reset is held six cycles, long enough to flush the pad filter too
	task automatic do_reset();
		sys_rst = 1'b1;
		board   = '1;
		src     = '1;
		repeat (6) @(negedge clk);
		chk("sel_state", {PIN_N{CODE_GPIO}}, sel_state);
		chk("pad_oe_n", {PIN_N{1'b1}}, pad_oe_n);
		sys_rst = 1'b0;
	endtask

	task automatic stop_test();
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// a hung run counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		{sel_wr_en, sel_wr_pin, sel_wr_code, spi_mode, spi_master} = '0;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		do_reset();
		// outputs: a one-hot source must reach its pin, two cycles after the write
		for (int i = 0; i < ot.size(); i += 4) begin
			do_reset();
			spi_mode   = ot[i+2][3:0];
			spi_master = ot[i+2][3:0];
			src        = '0;
			src[ot[i+3]] = 1'b1;
			sel_write(ot[i], ot[i+1]);
			sel_read(ot[i], code);
			chk("sel code", ot[i+1], code);
			chk("pad_out", 1, pad_out[ot[i]]);
			chk("pad_oe_n", 0, pad_oe_n[ot[i]]);
			src = ~src;
			@(negedge clk);
			chk("pad_out", 0, pad_out[ot[i]]);
		end
		// inputs: a low pad must reach only its listed inputs, pad released
		for (int i = 0; i < it.size(); i += 5) begin
			do_reset();
			spi_mode   = it[i+2][3:0];
			spi_master = '0;
			sel_write(it[i], it[i+1]);
			board[it[i]] = 1'b0;
			repeat (6) @(negedge clk);
			exp = '1;
			exp[it[i+3]] = 1'b0;
			exp[it[i+4]] = 1'b0;
			chk("routed inputs", exp, inv);
			chk("gpio_in", 0, gpio_in[it[i]]);
			chk("pad_oe_n", 1, pad_oe_n[it[i]]);
		end
		// primary and duplicate chosen together: the primary pin wins
		do_reset();
		sel_write(1, 2);
		sel_write(13, 1);
		board[13] = 1'b0;
		repeat (6) @(negedge clk);
		chk("ext_irq_in", 4'hf, ext_irq_in);
		board = 36'hffffffffd;
		repeat (6) @(negedge clk);
		chk("ext_irq_in", 4'he, ext_irq_in);
		src = '0;
		src[101] = 1'b1;
		sel_write(32, 2);
		sel_write(28, 2);
		chk("pad_out", 1, pad_out[32]);
		chk("pad_oe_n", 1, pad_oe_n[28]);
		sel_write(6, 1);
		sel_write(16, 1);
		chk("pad_oe_n", 1, pad_oe_n[16]);
		chk("pad_oe_n", 0, pad_oe_n[6]);
		// out-of-range pin is ignored, a reserved code leaves the pad released
		do_reset();
		sel_write(40, 1);
		chk("sel_state", {PIN_N{CODE_GPIO}}, sel_state);
		sel_write(8, 1);
		chk("pad_oe_n", 1, pad_oe_n[8]);
		stop_test();
	end
endmodule
